//--- common/bsc_pkg.sv
// Package of constants for the bit-operation, skip and call execution block.
`default_nettype none
package bsc_pkg;
  // ==========================================================================
  // Widths
  localparam int INSTR_W = 13;
  localparam int PC_W = 11;
  localparam int REG_ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int BIT_SEL_W = 3;
  localparam int CALL_IMM_W = 10;
  // ==========================================================================
  // Opcode fields: bit ops use [12:9] opcode, [8:6] bit, [5:0] register.
  localparam int OPC_HI = 12;
  localparam int OPC_LO = 9;
  localparam int BIT_HI = 8;
  localparam int BIT_LO = 6;
  localparam int REG_HI = 5;
  localparam int REG_LO = 0;
  localparam int CALL_OPC_HI = 12;
  localparam int CALL_OPC_LO = 10;
  localparam int IMM_HI = 9;
  localparam int PAGE_BIT = 2;
  localparam logic [3:0] OPC_BIT_CLEAR = 4'h4;
  localparam logic [3:0] OPC_BIT_SET = 4'h5;
  localparam logic [3:0] OPC_SKIP_CLEAR = 4'h6;
  localparam logic [3:0] OPC_SKIP_SET = 4'h7;
  localparam logic [2:0] OPC_CALL = 3'h6;
  localparam logic [12:0] NOP_WORD = 13'h0000;
  localparam logic [10:0] PC_RESET = 11'h000;
  localparam logic [10:0] PC_ONE = 11'h001;
  localparam logic [7:0] DATA_ONE = 8'h01;
  typedef enum logic [1:0] {ST_RUN, ST_FLUSH} bsc_state_t;
endpackage
`default_nettype wire

//--- logic/bsc_bit_unit.sv
// Bit modify and bit test datapath for one register byte.
`timescale 1ns/1ns
`default_nettype none
module bsc_bit_unit
  import bsc_pkg::*;
(
  // Operand
  input wire logic [DATA_W-1:0] dataIn,
  input wire logic [BIT_SEL_W-1:0] bitSel,
  // Results
  output logic [DATA_W-1:0] clearedData,
  output logic [DATA_W-1:0] setData,
  output logic bitValue
);
  logic [DATA_W-1:0] mask;
  always_comb begin
    mask = DATA_ONE << bitSel;
    clearedData = dataIn & ~mask;
    setData = dataIn | mask;
    bitValue = |(dataIn & mask);
  end
endmodule
`default_nettype wire

//--- logic/bsc_exec.sv
// Execution of bit clear, bit set, bit test skips and subroutine call.
// Operation
// - Bit clear zeroes the chosen bit of the addressed register and keeps the other seven.
// - Bit set makes the chosen bit one in a single cycle with no flag change.
// - Skip-if-clear suppresses the next instruction when the tested bit is zero.
// - On that skip the prefetched word is replaced by a NOP, giving two cycles, else one.
// - Skip-if-set suppresses the next instruction when the tested bit is one, no flag change.
// - On that skip the prefetched word becomes a NOP, giving two cycles instead of one.
// - A call first pushes the program counter plus one onto the return stack.
// - A call loads its 10-bit operand into counter bits 9..0 and page buffer bit 2 into bit 10.
// - A call takes two cycles and changes no status flag.
`timescale 1ns/1ns
`default_nettype none
module bsc_exec
  import bsc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Fetch path
  input wire logic [INSTR_W-1:0] fetchWord,
  input wire logic [DATA_W-1:0] pageHighBuffer,
  // Register file read port, combinational on regAddr
  input wire logic [DATA_W-1:0] regReadData,
  output logic [REG_ADDR_W-1:0] regAddr,
  // Register file write port
  output logic regWrite,
  output logic [REG_ADDR_W-1:0] regWriteAddr,
  output logic [DATA_W-1:0] regWriteData,
  // Stack and program counter
  output logic stackPush,
  output logic [PC_W-1:0] stackData,
  output logic [PC_W-1:0] progCounter,
  // Status
  output logic flagWrite,
  output logic busy
);
  // ==========================================================================
  // Decode of the word in execute
  logic [3:0] opcode;
  logic [BIT_SEL_W-1:0] bitSel;
  logic [REG_ADDR_W-1:0] addrField;
  logic isClear, isSet, isSkipClr, isSkipSet, isCall;
  logic [DATA_W-1:0] clearedData, setData;
  logic bitValue;
  logic skipTaken;

  bsc_state_t state_reg, state_next;
  logic [INSTR_W-1:0] execWord;
  logic [PC_W-1:0] pc_reg, pc_next;
  logic regWrite_reg, regWrite_next;
  logic [REG_ADDR_W-1:0] wAddr_reg, wAddr_next;
  logic [DATA_W-1:0] wData_reg, wData_next;
  logic push_reg, push_next;
  logic [PC_W-1:0] stack_reg, stack_next;
  logic busy_reg, busy_next;
  logic flag_reg, flag_next;
  logic [DATA_W-1:0] operand;

  // In flush state the prefetched word is discarded and a NOP executes.
  assign execWord = (state_reg == ST_FLUSH) ? NOP_WORD : fetchWord;
  assign opcode = execWord[OPC_HI:OPC_LO];
  assign bitSel = execWord[BIT_HI:BIT_LO];
  assign addrField = execWord[REG_HI:REG_LO];
  assign isClear = (opcode == OPC_BIT_CLEAR);
  assign isSet = (opcode == OPC_BIT_SET);
  assign isSkipClr = (opcode == OPC_SKIP_CLEAR);
  assign isSkipSet = (opcode == OPC_SKIP_SET);
  assign isCall = (execWord[CALL_OPC_HI:CALL_OPC_LO] == OPC_CALL);

  // ==========================================================================
  // Operand forwarding
  // The register file commits a write at the edge after the write strobe, so a
  // bit operation on the same register in the very next cycle would still read
  // the old byte there. Forwarding the pending write keeps each bit operation a
  // true read-modify-write even when two of them hit one register back to back.
  assign operand = (regWrite_reg && (wAddr_reg == addrField)) ?
    wData_reg : regReadData;

  bsc_bit_unit u_bit (
    .dataIn(operand),
    .bitSel(bitSel),
    .clearedData(clearedData),
    .setData(setData),
    .bitValue(bitValue)
  );

  assign skipTaken = (isSkipClr && !bitValue) || (isSkipSet && bitValue);

  // ==========================================================================
  // Next-state logic
  always_comb begin
    state_next = ST_RUN;
    // The counter also steps in a flush cycle, which walks past the discarded word.
    pc_next = pc_reg + PC_ONE;
    regWrite_next = 1'b0;
    wAddr_next = addrField;
    wData_next = wData_reg;
    push_next = 1'b0;
    stack_next = stack_reg;
    busy_next = 1'b0;
    flag_next = 1'b0;
    // Only one class can decode at a time; the chain order just fixes the
    // priority should an unused encoding ever alias two of them.
    if (isClear) begin
      regWrite_next = 1'b1;
      wData_next = clearedData;
    end else if (isSet) begin
      regWrite_next = 1'b1;
      wData_next = setData;
    end else if (skipTaken) begin
      state_next = ST_FLUSH;
      busy_next = 1'b1;
    end else if (isCall) begin
      push_next = 1'b1;
      stack_next = pc_reg + PC_ONE;
      pc_next = {pageHighBuffer[PAGE_BIT], execWord[IMM_HI:0]};
      state_next = ST_FLUSH;
      busy_next = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= ST_RUN;
      pc_reg <= PC_RESET;
      regWrite_reg <= 1'b0;
      wAddr_reg <= '0;
      wData_reg <= '0;
      push_reg <= 1'b0;
      stack_reg <= PC_RESET;
      busy_reg <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      regWrite_reg <= regWrite_next;
      wAddr_reg <= wAddr_next;
      wData_reg <= wData_next;
      push_reg <= push_next;
      stack_reg <= stack_next;
      busy_reg <= busy_next;
      flag_reg <= flag_next;
    end
  end

  // The read address follows the decode combinationally so the modify sees current data.
  assign regAddr = addrField;
  assign regWrite = regWrite_reg;
  assign regWriteAddr = wAddr_reg;
  assign regWriteData = wData_reg;
  assign stackPush = push_reg;
  assign stackData = stack_reg;
  assign progCounter = pc_reg;
  assign busy = busy_reg;
  // None of these instructions touch status flags.
  assign flagWrite = flag_reg;

  // ==========================================================================
  // Assertions
  sequence s_skip;
    (isSkipClr && !bitValue && state_reg == ST_RUN) ||
    (isSkipSet && bitValue && state_reg == ST_RUN);
  endsequence
  sequence s_flush;
    state_reg == ST_FLUSH ##1 state_reg == ST_RUN;
  endsequence

  a_clear_bit: assert property (@(posedge clock) disable iff (!rst_n)
    (isClear && state_reg == ST_RUN) |=> regWrite &&
      regWriteData == ($past(operand) & ~(DATA_ONE << $past(bitSel))))
    else $error("bit clear wrote wrong data");
  a_set_bit: assert property (@(posedge clock) disable iff (!rst_n)
    (isSet && state_reg == ST_RUN) |=> regWrite && regWriteData[$past(bitSel)] &&
      regWriteAddr == $past(addrField))
    else $error("bit set wrote wrong data");
  a_skip_flush: assert property (@(posedge clock) disable iff (!rst_n)
    s_skip |=> s_flush)
    else $error("skip did not flush one cycle");
  a_no_skip: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == ST_RUN && (isSkipClr || isSkipSet) && !skipTaken) |=> state_reg == ST_RUN)
    else $error("skip taken wrongly");
  a_flush_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == ST_FLUSH |=> !regWrite && !stackPush && !busy)
    else $error("discarded word took effect");
  a_call_push: assert property (@(posedge clock) disable iff (!rst_n)
    (isCall && state_reg == ST_RUN) |=> stackPush && stackData == $past(pc_reg) + PC_ONE)
    else $error("call push wrong");
  a_call_target: assert property (@(posedge clock) disable iff (!rst_n)
    (isCall && state_reg == ST_RUN) |=>
      progCounter == {$past(pageHighBuffer[PAGE_BIT]), $past(execWord[IMM_HI:0])})
    else $error("call target wrong");
  a_call_cycles: assert property (@(posedge clock) disable iff (!rst_n)
    (isCall && state_reg == ST_RUN) |=> busy ##1 !busy && !flagWrite)
    else $error("call length wrong");
  a_rmw_single: assert property (@(posedge clock) disable iff (!rst_n)
    regWrite |-> !busy && !flagWrite)
    else $error("bit op not single cycle");

  // Two bit operations on one register in a row must build on each other.
  a_fwd_set: assert property (@(posedge clock) disable iff (!rst_n)
    (isSet && regWrite && regWriteAddr == addrField) |=>
      regWriteData == ($past(regWriteData) | (DATA_ONE << $past(bitSel))))
    else $error("bit set lost a pending write");
  a_fwd_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (isClear && regWrite && regWriteAddr == addrField) |=>
      regWriteData == ($past(regWriteData) & ~(DATA_ONE << $past(bitSel))))
    else $error("bit clear lost a pending write");
  a_clear_addr: assert property (@(posedge clock) disable iff (!rst_n)
    isClear |=> regWrite && regWriteAddr == $past(addrField))
    else $error("bit clear wrote wrong register");
  a_skip_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    s_skip |=> busy && !regWrite && !stackPush)
    else $error("skip test changed state");
  a_pc_advance: assert property (@(posedge clock) disable iff (!rst_n)
    !isCall |=> progCounter == $past(progCounter) + PC_ONE)
    else $error("counter did not step");
  a_busy_single: assert property (@(posedge clock) disable iff (!rst_n)
    busy |=> !busy)
    else $error("flush lasted too long");
endmodule
`default_nettype wire

//--- sim/bsc_exec_bench.sv
// Self-checking bench for the bit-operation, skip and call execution block.
`timescale 1ns/1ns
`default_nettype none
module bsc_exec_bench;
  import bsc_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [INSTR_W-1:0] fetchWord = NOP_WORD;
  logic [DATA_W-1:0] pageHighBuffer = 8'h00;
  logic [DATA_W-1:0] regReadData;
  logic [REG_ADDR_W-1:0] regAddr;
  logic [REG_ADDR_W-1:0] regWriteAddr;
  logic [DATA_W-1:0] regWriteData;
  logic [PC_W-1:0] stackData;
  logic [PC_W-1:0] progCounter;
  logic regWrite, stackPush, flagWrite, busy;
  logic [DATA_W-1:0] regs [64];
  logic [DATA_W-1:0] regsM [64];
  logic [23:0] notes [$];
  int errors = 0;
  int n_checks = 0;
  assign regReadData = regs[regAddr];
  bsc_exec i_dut (.clock(clock), .rst_n(rst_n), .fetchWord(fetchWord),
    .pageHighBuffer(pageHighBuffer), .regReadData(regReadData), .regAddr(regAddr),
    .regWrite(regWrite), .regWriteAddr(regWriteAddr), .regWriteData(regWriteData),
    .stackPush(stackPush), .stackData(stackData), .progCounter(progCounter),
    .flagWrite(flagWrite), .busy(busy));
  initial begin
    forever #10 clock = ~clock;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic check(input string name, input logic [10:0] seen, input logic [10:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic take(input logic [1:0] kind, input logic [10:0] a, input logic [10:0] d);
    logic [23:0] n;
    n = (notes.size() > 0) ? notes.pop_front() : 24'h000000;
    check("event kind", {9'h000, kind}, {9'h000, n[23:22]});
    check("first value", a, n[21:11]);
    check("second value", d, n[10:0]);
  endtask
  task automatic final_report();
    if (errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========================================================================
  // Output watcher: every strobe must match the oldest pending note.
  always @(negedge clock) begin
    if (rst_n) begin
      check("flagWrite", {10'h000, flagWrite}, 11'h000);
      if (regWrite === 1'b1) take(2'h1, {5'h00, regWriteAddr}, {3'h0, regWriteData});
      if (stackPush === 1'b1) take(2'h2, stackData, progCounter);
      if (busy === 1'b1) take(2'h3, 11'h000, 11'h000);
    end
  end
  // ==========================================================================
  // Driver and reference model.
  initial begin
    logic [31:0] seed;
    logic [3:0] opcs [4];
    logic [PC_W-1:0] pcM;
    logic [PC_W-1:0] target;
    logic [DATA_W-1:0] d;
    logic [INSTR_W-1:0] w;
    logic [2:0] op;
    logic flushM;
    seed = 32'd64869;
    opcs = '{OPC_BIT_CLEAR, OPC_BIT_SET, OPC_SKIP_CLEAR, OPC_SKIP_SET};
    pcM = PC_ONE;
    flushM = 1'b0;
    for (int r = 0; r < 64; r++) begin
      seed = xs(seed);
      regs[r] = seed[7:0];
      regsM[r] = seed[7:0];
    end
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 600; i++) begin
      @(posedge clock);
      // The register file commits a strobed write at the following edge.
      if (regWrite === 1'b1) regs[regWriteAddr] <= regWriteData;
      seed = xs(seed);
      op = seed[21:19];
      if (op == 3'h4) w = {OPC_CALL, seed[9:0]};
      else if (op < 3'h4) w = {opcs[op[1:0]], seed[8:6],
        seed[18] ? {3'h0, seed[2:0]} : seed[5:0]};
      else w = NOP_WORD;
      fetchWord <= w;
      pageHighBuffer <= seed[31:24];
      d = regsM[w[5:0]];
      target = {seed[26], seed[9:0]};
      if (flushM) begin
        flushM = 1'b0;
      end else if (op == 3'h4) begin
        notes.push_back({2'h2, pcM + PC_ONE, target});
        notes.push_back({2'h3, 22'h000000});
        flushM = 1'b1;
        pcM = target - PC_ONE;
      end else if (op == 3'h0) begin
        notes.push_back({2'h1, 5'h00, w[5:0], 3'h0, d & ~(DATA_ONE << w[8:6])});
        regsM[w[5:0]] = d & ~(DATA_ONE << w[8:6]);
      end else if (op == 3'h1) begin
        notes.push_back({2'h1, 5'h00, w[5:0], 3'h0, d | (DATA_ONE << w[8:6])});
        regsM[w[5:0]] = d | (DATA_ONE << w[8:6]);
      end else if (op < 3'h4 && d[w[8:6]] == op[0]) begin
        notes.push_back({2'h3, 22'h000000});
        flushM = 1'b1;
      end
      pcM = pcM + PC_ONE;
    end
    @(posedge clock);
    fetchWord <= NOP_WORD;
    for (int k = 0; k < 8 && notes.size() > 0; k++) @(posedge clock);
    @(posedge clock);
    if (notes.size() > 0) errors++;
    final_report();
  end
endmodule
`default_nettype wire
